// ### logic/io_register_space_decode.sv
/*
  Peripheral register space decoder: holds the peripheral registers in flip-flops and
  serves the core's I/O, single-bit and load/store accesses, one command per cycle.
  Assumes the core holds a command for one cycle and that pin levels are synchronous.
*/
`timescale 1ns/10ps

module io_register_space_decode #(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire io_space_pkg::cmd_e cmd,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] bit_sel,
  input wire logic [io_space_pkg::NPORT*8-1:0] pins_in,
  input wire logic tx_done_event,
  output logic [7:0] rdata,
  output logic skip,
  output logic done,
  output logic refused,
  output logic [io_space_pkg::NREG*8-1:0] reg_image
);

  // ==========================================================================
  // Elaboration check
  if (DATA_W != 8) begin : g_width_check
    $error("DATA_W must be 8.");
  end

  // ==========================================================================
  // Decode
  function automatic logic [6:0] find_index(input logic [8:0] daddr);
    logic [6:0] result;
    result = 7'h7F;
    for (int k = 0; k < io_space_pkg::NREG; k++) begin
      if (io_space_pkg::REG_ADDR[k] == daddr) begin
        result = 7'(k);
      end
    end
    return result;
  endfunction : find_index

  logic [7:0] regs [io_space_pkg::NREG];
  logic [7:0] next_regs [io_space_pkg::NREG];
  logic is_io_cmd;
  logic is_bit_cmd;
  logic is_ld_cmd;
  logic is_st_cmd;
  logic bad_addr;
  logic [8:0] daddr;
  logic [6:0] idx;
  logic hit;
  logic [7:0] cur;
  logic [7:0] bit_mask;
  logic [7:0] wval;
  logic wr_en;
  logic rd_en;

  always_comb begin
    is_io_cmd = (cmd == io_space_pkg::CMD_IO_IN) || (cmd == io_space_pkg::CMD_IO_OUT);
    is_bit_cmd = (cmd == io_space_pkg::CMD_SET_BIT) || (cmd == io_space_pkg::CMD_CLR_BIT)
      || (cmd == io_space_pkg::CMD_SKIP_ONE) || (cmd == io_space_pkg::CMD_SKIP_ZERO);
    is_ld_cmd = (cmd == io_space_pkg::CMD_LOAD);
    is_st_cmd = (cmd == io_space_pkg::CMD_STORE);
    // I/O view is 00-3F; bit view only 00-1F; data space starts above the file.
    if (is_io_cmd) begin
      bad_addr = addr > io_space_pkg::IO_LAST;
    end else if (is_bit_cmd) begin
      bad_addr = addr > io_space_pkg::BIT_IO_LAST;
    end else begin
      bad_addr = addr < io_space_pkg::IO_OFFSET || addr > io_space_pkg::EXT_LAST;
    end
    // I/O addresses map into data space shifted by the fixed offset.
    if (is_io_cmd || is_bit_cmd) begin
      daddr = 9'(addr + io_space_pkg::IO_OFFSET);
    end else begin
      daddr = addr;
    end
    idx = find_index(daddr);
    hit = (idx != 7'h7F) && !bad_addr;
    if (!hit) begin
      cur = 8'h00;
    end else if (io_space_pkg::PIN_SEL[idx[5:0]] != io_space_pkg::NO_PIN) begin
      cur = pins_in[io_space_pkg::PIN_SEL[idx[5:0]]*8 +: 8];
    end else begin
      cur = regs[idx[5:0]] & io_space_pkg::RMASK[idx[5:0]];
    end
    bit_mask = 8'h01 << bit_sel;
    // Bit operations rewrite the full register as read back.
    unique case (cmd)
      io_space_pkg::CMD_SET_BIT: wval = cur | bit_mask;
      io_space_pkg::CMD_CLR_BIT: wval = cur & ~bit_mask;
      default: wval = wdata;
    endcase
    wr_en = hit && (is_st_cmd || cmd == io_space_pkg::CMD_IO_OUT
      || cmd == io_space_pkg::CMD_SET_BIT || cmd == io_space_pkg::CMD_CLR_BIT);
    rd_en = hit && (is_ld_cmd || cmd == io_space_pkg::CMD_IO_IN);
  end

  // ==========================================================================
  // Register storage
  for (genvar i = 0; i < io_space_pkg::NREG; i++) begin : g_reg
    always_comb begin
      next_regs[i] = regs[i];
      if (wr_en && idx == 7'(i)) begin
        next_regs[i] = (regs[i] & ~io_space_pkg::WMASK[i]) | (wval & io_space_pkg::WMASK[i]);
        if (i == io_space_pkg::SERIAL0_STATUS_IDX) begin
          next_regs[i] = next_regs[i] & ~(wval & io_space_pkg::TX_DONE_FLAG);
        end
      end
      // A new event wins over a clear in the same cycle.
      if (i == io_space_pkg::SERIAL0_STATUS_IDX && tx_done_event) begin
        next_regs[i] = next_regs[i] | io_space_pkg::TX_DONE_FLAG;
      end
    end
    assign reg_image[i*8 +: 8] = regs[i];
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < io_space_pkg::NREG; i++) begin
      if (srst) begin
        regs[i] <= io_space_pkg::RESET_VALUE;
      end else begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // ==========================================================================
  // Answers to the core
  always_ff @(posedge clk) begin
    if (srst) begin
      done <= 1'b0;
      refused <= 1'b0;
    end else begin
      done <= cmd != io_space_pkg::CMD_IDLE;
      refused <= (cmd != io_space_pkg::CMD_IDLE) && bad_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (is_ld_cmd || cmd == io_space_pkg::CMD_IO_IN) begin
      rdata <= rd_en ? cur : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      skip <= 1'b0;
    end else if (cmd == io_space_pkg::CMD_SKIP_ONE) begin
      skip <= hit && ((cur & bit_mask) != 8'h00);
    end else if (cmd == io_space_pkg::CMD_SKIP_ZERO) begin
      skip <= hit && ((cur & bit_mask) == 8'h00);
    end else begin
      skip <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  logic [6:0] chk_idx_q;
  logic [7:0] chk_mask_q;
  logic [7:0] chk_cur_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      chk_idx_q <= 7'h7F;
      chk_mask_q <= 8'h00;
      chk_cur_q <= 8'h00;
    end else begin
      chk_idx_q <= hit ? idx : 7'h7F;
      chk_mask_q <= bit_mask;
      chk_cur_q <= cur;
    end
  end

  chk_bit_set_lands: assert property (@(posedge clk) disable iff (srst)
    (cmd == io_space_pkg::CMD_SET_BIT && hit && (io_space_pkg::WMASK[idx[5:0]] & bit_mask) != 8'h00)
    |=> (regs[chk_idx_q[5:0]] & chk_mask_q) != 8'h00)
    else $error("Bit set did not reach the register.");

  chk_bit_clr_lands: assert property (@(posedge clk) disable iff (srst)
    (cmd == io_space_pkg::CMD_CLR_BIT && hit && !tx_done_event)
    |=> (regs[chk_idx_q[5:0]] & chk_mask_q) == 8'h00)
    else $error("Bit clear did not reach the register.");

  chk_skip_one_value: assert property (@(posedge clk) disable iff (srst)
    (cmd == io_space_pkg::CMD_SKIP_ONE && hit)
    |=> skip == ((chk_cur_q & chk_mask_q) != 8'h00))
    else $error("Skip answer does not match the tested bit.");

  chk_flag_w1c: assert property (@(posedge clk) disable iff (srst)
    (is_st_cmd && daddr == io_space_pkg::REG_ADDR[io_space_pkg::SERIAL0_STATUS_IDX]
      && wdata[6] && !tx_done_event)
    |=> regs[io_space_pkg::SERIAL0_STATUS_IDX][6] == 1'b0)
    else $error("Writing one did not clear the flag.");

  chk_flag_zero_keeps: assert property (@(posedge clk) disable iff (srst)
    (is_st_cmd && daddr == io_space_pkg::REG_ADDR[io_space_pkg::SERIAL0_STATUS_IDX]
      && !wdata[6] && regs[io_space_pkg::SERIAL0_STATUS_IDX][6])
    |=> regs[io_space_pkg::SERIAL0_STATUS_IDX][6])
    else $error("Writing zero disturbed the flag.");

  chk_event_beats_clear: assert property (@(posedge clk) disable iff (srst)
    tx_done_event |=> regs[io_space_pkg::SERIAL0_STATUS_IDX][6])
    else $error("Flag event was lost.");

  chk_bit_range_refused: assert property (@(posedge clk) disable iff (srst)
    (is_bit_cmd && addr > io_space_pkg::BIT_IO_LAST && !tx_done_event)
    |=> refused && !skip && $stable(reg_image))
    else $error("Bit operation above the bit range was honoured.");

  chk_io_range_refused: assert property (@(posedge clk) disable iff (srst)
    (is_io_cmd && addr > io_space_pkg::IO_LAST) |=> refused && done)
    else $error("I/O command outside the I/O view was honoured.");

  chk_io_offset_map: assert property (@(posedge clk) disable iff (srst)
    (cmd == io_space_pkg::CMD_IO_IN && addr == 9'h000) |=> rdata == $past(pins_in[7:0]))
    else $error("I/O address did not map at the fixed offset.");

  chk_reserved_reads_zero: assert property (@(posedge clk) disable iff (srst)
    (is_ld_cmd && !hit) |=> rdata == 8'h00)
    else $error("Reserved address did not read zero.");

  chk_reserved_write_ignored: assert property (@(posedge clk) disable iff (srst)
    (is_st_cmd && !hit && !tx_done_event) |=> $stable(reg_image))
    else $error("Reserved write changed a register.");

  // ==========================================================================
  // Answer timing, extra range, skip-zero value and input-entry checks
  chk_done_follows_cmd: assert property (@(posedge clk) disable iff (srst)
    (cmd != io_space_pkg::CMD_IDLE) |=> done)
    else $error("Command was not answered in the next cycle.");

  chk_idle_quiet: assert property (@(posedge clk) disable iff (srst)
    (cmd == io_space_pkg::CMD_IDLE) |=> !done && !refused && !skip)
    else $error("Answer appeared without a command.");

  chk_skip_zero_value: assert property (@(posedge clk) disable iff (srst)
    (cmd == io_space_pkg::CMD_SKIP_ZERO && hit)
    |=> skip == ((chk_cur_q & chk_mask_q) == 8'h00))
    else $error("Skip answer does not match the cleared bit.");

  chk_low_data_refused: assert property (@(posedge clk) disable iff (srst)
    ((is_ld_cmd || is_st_cmd) && addr < io_space_pkg::IO_OFFSET && !tx_done_event)
    |=> refused && rdata == 8'h00 && $stable(reg_image))
    else $error("Data access below the register file was honoured.");

  chk_read_data_holds: assert property (@(posedge clk) disable iff (srst)
    !(is_ld_cmd || cmd == io_space_pkg::CMD_IO_IN) |=> $stable(rdata))
    else $error("Read data changed without a read.");

  chk_input_entry_zero: assert property (@(posedge clk) disable iff (srst)
    regs[0] == 8'h00 && regs[3] == 8'h00 && regs[6] == 8'h00)
    else $error("Input-level entry was written.");

endmodule : io_register_space_decode

// ### logic/io_space_pkg.sv
/*
  Constants for the peripheral register space decoder: address windows, register table,
  field masks and the command set seen from the core.
  Assumes a single 8-bit data path and a 9-bit data-space address.
*/
package io_space_pkg;

  // ==========================================================================
  // Address windows
  localparam int NREG = 48;
  localparam int NPORT = 7;
  localparam logic [8:0] IO_OFFSET = 9'h020;
  localparam logic [8:0] BIT_IO_LAST = 9'h01F;
  localparam logic [8:0] IO_LAST = 9'h03F;
  localparam logic [8:0] EXT_FIRST = 9'h060;
  localparam logic [8:0] EXT_LAST = 9'h1FF;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ==========================================================================
  // Register table, one entry per mapped data-space address.
  localparam logic [8:0] REG_ADDR [NREG] = '{
    9'h020, 9'h021, 9'h022, 9'h023, 9'h024, 9'h025, 9'h026, 9'h027,
    9'h03E, 9'h03F, 9'h040, 9'h041, 9'h042, 9'h043, 9'h044, 9'h045,
    9'h046, 9'h047, 9'h048, 9'h0C0, 9'h0C1, 9'h0C2, 9'h0C4, 9'h0C5,
    9'h0C6, 9'h100, 9'h102, 9'h103, 9'h104, 9'h105, 9'h106, 9'h107,
    9'h108, 9'h109, 9'h10A, 9'h10B, 9'h120, 9'h121, 9'h122, 9'h124,
    9'h125, 9'h126, 9'h127, 9'h128, 9'h129, 9'h12A, 9'h12B, 9'h12C};

  // Input-level registers read a pin group; 7 marks a stored register.
  localparam logic [2:0] NO_PIN = 3'h7;
  localparam logic [2:0] PIN_SEL [NREG] = '{
    3'h0, 3'h7, 3'h7, 3'h1, 3'h7, 3'h7, 3'h2, 3'h7,
    3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7,
    3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7,
    3'h7, 3'h3, 3'h7, 3'h4, 3'h7, 3'h7, 3'h5, 3'h7,
    3'h7, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7,
    3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};

  // Bits that software may write.
  localparam logic [7:0] WMASK [NREG] = '{
    8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF,
    8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h83, 8'hF3, 8'hCF,
    8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
    8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF,
    8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hDF, 8'hE0, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  // Bits that read back; strobe and reserved bits read as zero.
  localparam logic [7:0] RMASK [NREG] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h83, 8'hF3, 8'h0F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hDF, 8'h00, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  // Flags cleared by writing one.
  localparam int SERIAL0_STATUS_IDX = 19;
  localparam logic [7:0] TX_DONE_FLAG = 8'h40;

  // ==========================================================================
  // Core commands
  typedef enum logic [3:0] {
    CMD_IDLE = 4'h0,
    CMD_IO_IN = 4'h1,
    CMD_IO_OUT = 4'h2,
    CMD_SET_BIT = 4'h3,
    CMD_CLR_BIT = 4'h4,
    CMD_SKIP_ONE = 4'h5,
    CMD_SKIP_ZERO = 4'h6,
    CMD_LOAD = 4'h7,
    CMD_STORE = 4'h8
  } cmd_e;

endpackage : io_space_pkg

// ### bench/core_model.sv
/*
  Core model: issues one command at a time to the register space decoder and collects the answer.
  Assumes the decoder registers its answer on the same edge that takes the command.
*/
`timescale 1ns/10ps

// ==========================================================================
// Command issue
module core_model (
  input wire logic clk,
  output io_space_pkg::cmd_e cmd,
  output logic [8:0] addr,
  output logic [7:0] wdata,
  output logic [2:0] bit_sel,
  input wire logic [7:0] rdata,
  input wire logic skip,
  input wire logic done,
  input wire logic refused
);
  initial begin
    cmd = io_space_pkg::CMD_IDLE;
    addr = 9'h000;
    wdata = 8'h00;
    bit_sel = 3'h0;
  end

  // Holds the command for one cycle, then returns cmd to idle and drives the other lines to their inverse.
  task automatic run(input io_space_pkg::cmd_e c, input logic [8:0] a, input logic [7:0] w,
      input logic [2:0] b, output logic [7:0] rd, output logic sk, output logic rf,
      output logic dn);
    @(posedge clk);
    #1;
    cmd = c;
    addr = a;
    wdata = w;
    bit_sel = b;
    @(posedge clk);
    #1;
    cmd = io_space_pkg::CMD_IDLE;
    addr = ~a;
    wdata = ~w;
    bit_sel = ~b;
    rd = rdata;
    sk = skip;
    rf = refused;
    dn = done;
  endtask : run
endmodule : core_model

// ### bench/io_register_space_decode_bench.sv
/*
  Testbench for the register space decoder: command sequences with expected values.
  Assumes the core model in its own file and the package constants.
*/
`timescale 1ns/10ps

// ==========================================================================
// Bench top
module io_register_space_decode_bench;
  logic clk;
  logic srst;
  logic [55:0] pins_in;
  logic tx_done_event;
  io_space_pkg::cmd_e cmd;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [2:0] bit_sel;
  logic [7:0] rdata;
  logic skip;
  logic done;
  logic refused;
  logic [383:0] reg_image;
  logic [383:0] snap;
  logic [7:0] r_data;
  logic r_skip;
  logic r_ref;
  logic r_done;
  int mismatches;
  int n_compared;

  io_register_space_decode dut (.clk(clk), .srst(srst), .cmd(cmd), .addr(addr),
    .wdata(wdata), .bit_sel(bit_sel), .pins_in(pins_in), .tx_done_event(tx_done_event),
    .rdata(rdata), .skip(skip), .done(done), .refused(refused), .reg_image(reg_image));

  core_model core (.clk(clk), .cmd(cmd), .addr(addr), .wdata(wdata), .bit_sel(bit_sel),
    .rdata(rdata), .skip(skip), .done(done), .refused(refused));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ========================================================================
  // Checks and commands
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic op(input io_space_pkg::cmd_e c, input logic [8:0] a, input logic [7:0] w,
      input logic [2:0] b);
    core.run(c, a, w, b, r_data, r_skip, r_ref, r_done);
    chk("done", 8'h01, {7'h00, r_done});
  endtask : op

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // ========================================================================
  // Sequence
  initial begin
    mismatches = 0;
    n_compared = 0;
    srst = 1'b1;
    tx_done_event = 1'b0;
    pins_in = 56'h6C_5B_4A_39_28_17_C3;
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
    chk("reset_image", 8'h00, {7'h00, |reg_image});
    op(io_space_pkg::CMD_IO_IN, 9'h000, 8'h00, 3'h0);
    chk("io_in_pins", 8'hC3, r_data);
    op(io_space_pkg::CMD_IO_OUT, 9'h001, 8'hA5, 3'h0);
    chk("io_out_dir", 8'hA5, reg_image[15:8]);
    op(io_space_pkg::CMD_LOAD, 9'h021, 8'h00, 3'h0);
    chk("load_alias", 8'hA5, r_data);
    op(io_space_pkg::CMD_SET_BIT, 9'h001, 8'h00, 3'h1);
    chk("set_bit", 8'hA7, reg_image[15:8]);
    op(io_space_pkg::CMD_CLR_BIT, 9'h001, 8'h00, 3'h0);
    chk("clr_bit", 8'hA6, reg_image[15:8]);
    op(io_space_pkg::CMD_SKIP_ONE, 9'h001, 8'h00, 3'h7);
    chk("skip_one", 8'h01, {7'h00, r_skip});
    op(io_space_pkg::CMD_SKIP_ZERO, 9'h001, 8'h00, 3'h0);
    chk("skip_zero", 8'h01, {7'h00, r_skip});
    op(io_space_pkg::CMD_SKIP_ONE, 9'h001, 8'h00, 3'h0);
    chk("no_skip", 8'h00, {7'h00, r_skip});
    op(io_space_pkg::CMD_SET_BIT, 9'h020, 8'h00, 3'h2);
    chk("bit_refused", 8'h01, {7'h00, r_ref});
    chk("bit_no_write", 8'h00, reg_image[87:80]);
    op(io_space_pkg::CMD_IO_IN, 9'h040, 8'h00, 3'h0);
    chk("io_ext_refused", 8'h01, {7'h00, r_ref});
    op(io_space_pkg::CMD_STORE, 9'h102, 8'h5A, 3'h0);
    chk("ext_store", 8'h5A, reg_image[215:208]);
    op(io_space_pkg::CMD_LOAD, 9'h100, 8'h00, 3'h0);
    chk("ext_pins", 8'h39, r_data);
    @(posedge clk);
    #1;
    tx_done_event = 1'b1;
    @(posedge clk);
    #1;
    tx_done_event = 1'b0;
    chk("flag_set", 8'h40, reg_image[159:152] & 8'h40);
    op(io_space_pkg::CMD_STORE, 9'h0C0, 8'h00, 3'h0);
    chk("flag_kept", 8'h40, reg_image[159:152] & 8'h40);
    op(io_space_pkg::CMD_STORE, 9'h0C0, 8'h40, 3'h0);
    chk("flag_cleared", 8'h00, reg_image[159:152] & 8'h40);
    op(io_space_pkg::CMD_STORE, 9'h045, 8'hFF, 3'h0);
    op(io_space_pkg::CMD_LOAD, 9'h045, 8'h00, 3'h0);
    chk("reserved_bits", 8'h0F, r_data);
    snap = reg_image;
    op(io_space_pkg::CMD_STORE, 9'h0C3, 8'hFF, 3'h0);
    chk("reserved_write", 8'h00, {7'h00, |(snap ^ reg_image)});
    op(io_space_pkg::CMD_LOAD, 9'h0C3, 8'h00, 3'h0);
    chk("reserved_read", 8'h00, r_data);
    results();
  end
endmodule : io_register_space_decode_bench
